// ### rtl/ctpwm_consts.svh
`ifndef CTPWM_CONSTS_SVH
`define CTPWM_CONSTS_SVH

// register indices, byte address is four times the index
`define CTPWM_IDX_CLOCK     6'h00
`define CTPWM_IDX_WAVE      6'h01
`define CTPWM_IDX_ROUTE     6'h02
`define CTPWM_IDX_OVR       6'h03
`define CTPWM_IDX_CMD       6'h04
`define CTPWM_IDX_EVA       6'h08
`define CTPWM_IDX_STATUS    6'h0E
`define CTPWM_IDX_CAPA_LO   6'h22
`define CTPWM_IDX_CAPA_HI   6'h23
`define CTPWM_IDX_CAPB_LO   6'h24
`define CTPWM_IDX_CAPB_HI   6'h25
`define CTPWM_IDX_CMP_FIRST 6'h28
`define CTPWM_IDX_CMP_LAST  6'h2F

// field positions
`define CTPWM_ENABLE_BIT    0
`define CTPWM_SYNC_PRESCALE_FIELD_LSB  1
`define CTPWM_COUNTER_PRESCALE_FIELD_LSB   3
`define CTPWM_CLKSRC_LSB    5
`define CTPWM_ROUTE_D_BIT   7
`define CTPWM_ROUTE_C_BIT   6
`define CTPWM_FIFTY_BIT     3
`define CTPWM_AUPD_BIT      1
`define CTPWM_OVR_BIT       0
`define CTPWM_DISABLE_AT_CYCLE_END_BIT    7
`define CTPWM_CAPB_BIT      4
`define CTPWM_CAPA_BIT      3
`define CTPWM_RESTART_BIT   2
`define CTPWM_SYNC_BIT      1
`define CTPWM_SYNC_AT_CYCLE_END_BIT   0

// reset values and timing counts
`define CTPWM_REG_RESET     8'h00
`define CTPWM_CMP_RESET     12'h000
`define CTPWM_SYNC_LAST     2'h1
`define CTPWM_SHIFT_DIV1    3'h0
`define CTPWM_SHIFT_DIV4    3'h2
`define CTPWM_SHIFT_DIV32   3'h5

`endif

// ### rtl/ctpwm_pkg.sv
package ctpwm_pkg;
  typedef enum logic [1:0] {
    internal_fast_osc  = 2'b00,
    clk_src_reserved   = 2'b01,
    external_clock_src = 2'b10,
    system_clock_src   = 2'b11
  } ctpwm_clk_src_type;

  typedef enum logic [1:0] {
    single_ramp_mode = 2'b00,
    double_ramp_mode = 2'b01,
    quad_ramp_mode   = 2'b10,
    dual_slope_mode  = 2'b11
  } ctpwm_wave_mode_type;

  // encoding doubles as the override bit index except in single ramp mode
  typedef enum logic [1:0] {
    st_dead_a = 2'b00,
    st_on_a   = 2'b01,
    st_dead_b = 2'b10,
    st_on_b   = 2'b11
  } ctpwm_cycle_state_type;
endpackage : ctpwm_pkg

// ### rtl/ctpwm_prescaler.sv
`timescale 1ns/1ps
// divides a tick stream by two to the power of shift_in
module ctpwm_prescaler #(
  parameter int WIDTH = 5
) (
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  input  wire logic       tick_in,
  input  wire logic [2:0] shift_in,
  output logic            tick_out
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic [WIDTH-1:0] mask;

  // free running count, a tick passes when the low bits are all ones
  always_comb begin
    mask     = WIDTH'((32'h1 << shift_in) - 32'h1);
    cnt_d    = tick_in ? cnt_q + 1'b1 : cnt_q;
    tick_out = tick_in & ((cnt_q & mask) == mask);
  end

  // count register
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : ctpwm_prescaler

// ### rtl/ctpwm_top.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "ctpwm_consts.svh"
module ctpwm_top (
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  input  wire logic        osc_tick_in,
  input  wire logic        ext_tick_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             wave_a_out,
  output logic             wave_b_out,
  output logic             output_c_out,
  output logic             output_d_out
);
  import ctpwm_pkg::*;

  logic [7:0]  ctrl_q, ctrl_d, wave_q, wave_d, route_q, route_d;
  logic [7:0]  ovr_q, ovr_d, eva_q, eva_d;
  logic        run_q, run_d, en_rdy_q, en_rdy_d, cmd_rdy_q, cmd_rdy_d;
  logic [1:0]  en_cnt_q, en_cnt_d, cmd_cnt_q, cmd_cnt_d;
  logic [4:0]  cmd_q, cmd_d;
  logic        disable_at_cycle_end_q, disable_at_cycle_end_d, eoc_pend_q, eoc_pend_d;
  logic [11:0] cnt_q, cnt_d, cap_a_q, cap_a_d, cap_b_q, cap_b_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d, rd_word;
  logic        wa_q, wa_d, wb_q, wb_d, oc_q, oc_d, od_q, od_d;
  ctpwm_cycle_state_type state_q, state_d;
  logic [11:0] buf_w [4];
  logic [11:0] act_w [4];
  logic [5:0]  idx;
  logic [7:0]  wdat;
  logic        access, hit, wr, cmp_wr, cmp_hi, auto_req, load_now;
  logic        restart_now, cycle_end, src_tick, cnt_tick, sync_tick;
  logic [1:0]  cmp_k;
  logic [2:0]  cnt_shift;
  logic [4:0]  req;
  ctpwm_clk_src_type   clk_src;
  ctpwm_wave_mode_type wmode;

  // bus decode
  assign access  = psel_in & penable_in;
  assign idx     = paddr_in[7:2];
  assign wdat    = pwdata_in[7:0];
  assign wr      = access & pready_q & pwrite_in & pstrb_in[0] & hit;
  assign cmp_wr  = wr & (idx >= `CTPWM_IDX_CMP_FIRST) & (idx <= `CTPWM_IDX_CMP_LAST);
  assign cmp_k   = idx[2:1];
  assign cmp_hi  = idx[0];
  assign clk_src = ctpwm_clk_src_type'(ctrl_q[`CTPWM_CLKSRC_LSB+1:`CTPWM_CLKSRC_LSB]);
  assign wmode   = ctpwm_wave_mode_type'(wave_q[1:0]);

  always_comb begin
    case (clk_src)
      internal_fast_osc:  src_tick = osc_tick_in;
      external_clock_src: src_tick = ext_tick_in;
      system_clock_src:   src_tick = 1'b1;
      default:            src_tick = 1'b0; // reserved source gives no clock
    endcase
  end

  always_comb begin
    case (ctrl_q[`CTPWM_COUNTER_PRESCALE_FIELD_LSB+1:`CTPWM_COUNTER_PRESCALE_FIELD_LSB])
      2'h1:    cnt_shift = `CTPWM_SHIFT_DIV4;
      2'h2:    cnt_shift = `CTPWM_SHIFT_DIV32;
      default: cnt_shift = `CTPWM_SHIFT_DIV1;
    endcase
  end

  ctpwm_prescaler #(.WIDTH(5)) u_cnt_div (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .tick_in  (src_tick),
    .shift_in (cnt_shift),
    .tick_out (cnt_tick)
  );

  // sync prescale of the source clock
  ctpwm_prescaler #(.WIDTH(3)) u_sync_div (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .tick_in  (src_tick),
    .shift_in ({1'b0, ctrl_q[`CTPWM_SYNC_PRESCALE_FIELD_LSB+1:`CTPWM_SYNC_PRESCALE_FIELD_LSB]}),
    .tick_out (sync_tick)
  );

  // read mux and address check
  always_comb begin
    hit     = (paddr_in[1:0] == 2'h0);
    rd_word = 32'h0;
    case (idx)
      `CTPWM_IDX_CLOCK:   rd_word = {24'h0, ctrl_q};
      `CTPWM_IDX_WAVE:    rd_word = {24'h0, wave_q};
      `CTPWM_IDX_ROUTE:   rd_word = {24'h0, route_q};
      `CTPWM_IDX_OVR:     rd_word = {24'h0, ovr_q};
      `CTPWM_IDX_CMD:     rd_word = 32'h0; // strobes read as zero
      `CTPWM_IDX_EVA:     rd_word = {24'h0, eva_q};
      `CTPWM_IDX_STATUS:  rd_word = {30'h0, cmd_rdy_q, en_rdy_q};
      `CTPWM_IDX_CAPA_LO: rd_word = {24'h0, cap_a_q[7:0]};
      `CTPWM_IDX_CAPA_HI: rd_word = {28'h0, cap_a_q[11:8]};
      `CTPWM_IDX_CAPB_LO: rd_word = {24'h0, cap_b_q[7:0]};
      `CTPWM_IDX_CAPB_HI: rd_word = {28'h0, cap_b_q[11:8]};
      default: begin
        if (idx >= `CTPWM_IDX_CMP_FIRST && idx <= `CTPWM_IDX_CMP_LAST) begin
          rd_word = cmp_hi ? {28'h0, buf_w[cmp_k][11:8]} : {24'h0, buf_w[cmp_k][7:0]};
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  // one wait state, read data and error registered
  always_comb begin
    pready_d  = access & ~pready_q;
    prdata_d  = (access & ~pready_q & ~pwrite_in) ? rd_word : 32'h0;
    pslverr_d = access & ~pready_q & ~hit;
  end

  // plain configuration registers
  always_comb begin
    wave_d  = wave_q;
    route_d = route_q;
    ovr_d   = ovr_q;
    eva_d   = eva_q;
    if (wr && idx == `CTPWM_IDX_WAVE) begin
      wave_d = {6'h0, wdat[1:0]};
    end
    if (wr && idx == `CTPWM_IDX_ROUTE) begin
      route_d = wdat & 8'hCB;
    end
    if (wr && idx == `CTPWM_IDX_OVR) begin
      ovr_d = wdat;
    end
    if (wr && idx == `CTPWM_IDX_EVA) begin
      eva_d = wdat & 8'hD5;
    end
  end

  // auto update requests from compare clear high writes
  assign auto_req = cmp_wr & cmp_hi & route_q[`CTPWM_AUPD_BIT] &
                    ((cmp_k == 2'h3) | ((cmp_k == 2'h1) & route_q[`CTPWM_FIFTY_BIT]));
  assign req = (wr && idx == `CTPWM_IDX_CMD) ? (wdat[4:0] | {4'h0, auto_req})
                                             : {4'h0, auto_req};

  // enable and command synchronization
  always_comb begin
    ctrl_d      = ctrl_q;
    run_d       = run_q;
    en_rdy_d    = en_rdy_q;
    en_cnt_d    = en_cnt_q;
    cmd_rdy_d   = cmd_rdy_q;
    cmd_cnt_d   = cmd_cnt_q;
    cmd_d       = cmd_q;
    disable_at_cycle_end_d    = disable_at_cycle_end_q;
    eoc_pend_d  = eoc_pend_q;
    cap_a_d     = cap_a_q;
    cap_b_d     = cap_b_q;
    restart_now = 1'b0;
    load_now    = 1'b0;
    if (wr && idx == `CTPWM_IDX_CLOCK) begin
      if (!run_q) begin
        ctrl_d[7:1] = {1'b0, wdat[6:1]};
      end
      if (en_rdy_q) begin
        ctrl_d[0] = wdat[0];
        en_rdy_d  = 1'b0;
        en_cnt_d  = 2'h0;
      end
    end
    // enable reaches counter after two sync ticks
    if (!en_rdy_q && !disable_at_cycle_end_q && sync_tick) begin
      en_cnt_d = en_cnt_q + 2'h1;
      if (en_cnt_q == `CTPWM_SYNC_LAST) begin
        run_d    = ctrl_q[`CTPWM_ENABLE_BIT];
        en_rdy_d = 1'b1;
      end
    end
    // disable at cycle end, ready held low until then
    if (disable_at_cycle_end_q && (cycle_end || !run_q)) begin
      run_d     = 1'b0;
      ctrl_d[0] = 1'b0;
      en_rdy_d  = 1'b1;
      disable_at_cycle_end_d  = 1'b0;
    end
    // disable strobe only when no enable sync pending
    if (wr && idx == `CTPWM_IDX_CMD && wdat[`CTPWM_DISABLE_AT_CYCLE_END_BIT] && en_rdy_q) begin
      disable_at_cycle_end_d = 1'b1;
      en_rdy_d = 1'b0;
    end
    if (eoc_pend_q && cycle_end) begin
      load_now   = 1'b1;
      eoc_pend_d = 1'b0;
    end
    // command arrives after two sync ticks
    if (!cmd_rdy_q && sync_tick) begin
      cmd_cnt_d = cmd_cnt_q + 2'h1;
      if (cmd_cnt_q == `CTPWM_SYNC_LAST) begin
        cmd_rdy_d = 1'b1;
        cmd_d     = 5'h0;
        if (cmd_q[`CTPWM_CAPA_BIT]) begin
          cap_a_d = cnt_q;
        end
        if (cmd_q[`CTPWM_CAPB_BIT]) begin
          cap_b_d = cnt_q;
        end
        restart_now = cmd_q[`CTPWM_RESTART_BIT];
        if (cmd_q[`CTPWM_SYNC_BIT]) begin
          load_now = 1'b1;
        end
        if (cmd_q[`CTPWM_SYNC_AT_CYCLE_END_BIT]) begin
          eoc_pend_d = 1'b1;
        end
      end
    end
    // accept a new command only when ready
    if (cmd_rdy_q && req != 5'h0) begin
      cmd_d     = req;
      cmd_rdy_d = 1'b0;
      cmd_cnt_d = 2'h0;
    end
  end

  // compare buffers and active copies, fifty mode mirrors b into a
  for (genvar k = 0; k < 4; k++) begin : g_cmp
    logic [11:0] b_q, b_d, a_q, a_d;
    logic        sel;
    always_comb begin
      sel = cmp_wr & ((cmp_k == 2'(k)) |
            ((k < 2) & route_q[`CTPWM_FIFTY_BIT] & (cmp_k == 2'(k + 2))));
      b_d = b_q;
      a_d = load_now ? b_q : a_q;
      if (sel && cmp_hi) begin
        b_d[11:8] = wdat[3:0];
      end else if (sel) begin
        b_d[7:0] = wdat;
      end
    end
    always_ff @(posedge clock_in) begin
      if (reset_in) begin
        b_q <= `CTPWM_CMP_RESET;
        a_q <= `CTPWM_CMP_RESET;
      end else begin
        b_q <= b_d;
        a_q <= a_d;
      end
    end
    assign buf_w[k] = b_q;
    assign act_w[k] = a_q;
  end

  // counter runs through the four cycle states
  always_comb begin
    cnt_d     = cnt_q;
    state_d   = state_q;
    cycle_end = 1'b0;
    if (restart_now) begin
      cnt_d   = 12'h000;
      state_d = st_dead_a;
    end else if (run_q && cnt_tick) begin
      cnt_d = cnt_q + 12'h001;
      case (state_q)
        st_dead_a: if (cnt_q >= act_w[0]) state_d = st_on_a;
        st_on_a:   if (cnt_q >= act_w[1]) state_d = st_dead_b;
        st_dead_b: if (cnt_q >= act_w[2]) state_d = st_on_b;
        st_on_b: begin
          if (cnt_q >= act_w[3]) begin
            cycle_end = 1'b1;
            cnt_d     = 12'h000;
            state_d   = st_dead_a;
          end
        end
        default:   state_d = st_dead_a;
      endcase
    end
  end

  // waveform levels, override and routing
  always_comb begin
    wa_d = (state_q == st_on_a);
    wb_d = (state_q == st_on_b);
    if (route_q[`CTPWM_OVR_BIT]) begin
      if (wmode == single_ramp_mode) begin
        wa_d = (state_q == st_dead_a) ? ovr_q[1] : (state_q == st_on_a) ? ovr_q[0] : 1'b0;
        wb_d = (state_q == st_dead_b) ? ovr_q[7] : (state_q == st_on_b) ? ovr_q[6] : 1'b0;
      end else begin
        wa_d = ovr_q[{1'b0, state_q}];
        wb_d = ovr_q[{1'b1, state_q}];
      end
    end
    oc_d = route_q[`CTPWM_ROUTE_C_BIT] ? wb_d : wa_d;
    od_d = route_q[`CTPWM_ROUTE_D_BIT] ? wb_d : wa_d;
  end

  // all state registers but the compare copies in g_cmp
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ctrl_q     <= `CTPWM_REG_RESET;
      wave_q     <= `CTPWM_REG_RESET;
      route_q    <= `CTPWM_REG_RESET;
      ovr_q      <= `CTPWM_REG_RESET;
      eva_q      <= `CTPWM_REG_RESET;
      run_q      <= 1'b0;
      en_rdy_q   <= 1'b1;
      en_cnt_q   <= 2'h0;
      cmd_rdy_q  <= 1'b1;
      cmd_cnt_q  <= 2'h0;
      cmd_q      <= 5'h00;
      disable_at_cycle_end_q   <= 1'b0;
      eoc_pend_q <= 1'b0;
      cnt_q      <= 12'h000;
      state_q    <= st_dead_a;
      cap_a_q    <= 12'h000;
      cap_b_q    <= 12'h000;
      pready_q   <= 1'b0;
      prdata_q   <= 32'h0;
      pslverr_q  <= 1'b0;
      wa_q       <= 1'b0;
      wb_q       <= 1'b0;
      oc_q       <= 1'b0;
      od_q       <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      wave_q     <= wave_d;
      route_q    <= route_d;
      ovr_q      <= ovr_d;
      eva_q      <= eva_d;
      run_q      <= run_d;
      en_rdy_q   <= en_rdy_d;
      en_cnt_q   <= en_cnt_d;
      cmd_rdy_q  <= cmd_rdy_d;
      cmd_cnt_q  <= cmd_cnt_d;
      cmd_q      <= cmd_d;
      disable_at_cycle_end_q   <= disable_at_cycle_end_d;
      eoc_pend_q <= eoc_pend_d;
      cnt_q      <= cnt_d;
      state_q    <= state_d;
      cap_a_q    <= cap_a_d;
      cap_b_q    <= cap_b_d;
      pready_q   <= pready_d;
      prdata_q   <= prdata_d;
      pslverr_q  <= pslverr_d;
      wa_q       <= wa_d;
      wb_q       <= wb_d;
      oc_q       <= oc_d;
      od_q       <= od_d;
    end
  end

  assign prdata_out   = prdata_q;
  assign pready_out   = pready_q;
  assign pslverr_out  = pslverr_q;
  assign wave_a_out   = wa_q;
  assign wave_b_out   = wb_q;
  assign output_c_out = oc_q;
  assign output_d_out = od_q;

  // checks on the block's own behaviour
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sequence s_ctrl_wr;
    wr && idx == `CTPWM_IDX_CLOCK;
  endsequence
  sequence s_cmd_wr;
    wr && idx == `CTPWM_IDX_CMD;
  endsequence

  a_prot_fields: assert property (s_ctrl_wr and run_q |=> $stable(ctrl_q[6:1]))
    else $error("locked field changed while running");
  a_en_sync_start: assert property (s_ctrl_wr and en_rdy_q |=> !en_rdy_q)
    else $error("enable write did not start sync");
  a_en_sync_bound: assert property ((!en_rdy_q && !disable_at_cycle_end_q && clk_src == system_clock_src)
    |-> ##[0:20] en_rdy_q)
    else $error("enable sync took too long");
  // a busy command may still complete in the same cycle and clear itself
  a_cmd_ignored: assert property (s_cmd_wr and !cmd_rdy_q |=>
    cmd_q == ($past(sync_tick && cmd_cnt_q == `CTPWM_SYNC_LAST) ? 5'h00 : $past(cmd_q)))
    else $error("command accepted while busy");
  a_cmd_bound: assert property ((!cmd_rdy_q && clk_src == system_clock_src)
    |-> ##[0:20] cmd_rdy_q)
    else $error("command sync took too long");
  a_route_c_sel: assert property (##1 oc_q == ($past(route_q[6]) ? wb_q : wa_q))
    else $error("output c routed wrongly");
  a_route_d_sel: assert property (##1 od_q == ($past(route_q[7]) ? wb_q : wa_q))
    else $error("output d routed wrongly");
  a_fifty_copy: assert property ((cmp_wr && !cmp_hi && cmp_k == 2'h2 && route_q[3])
    |=> buf_w[0][7:0] == $past(wdat))
    else $error("fifty mode copy missing");
  a_ovr_one_ramp: assert property ((route_q[0] && wmode == single_ramp_mode
    && state_q == st_dead_a) |=> wa_q == $past(ovr_q[1]))
    else $error("one ramp override level wrong");
  a_disable_at_cycle_end_hold: assert property (disable_at_cycle_end_q |-> !en_rdy_q ##1 (!en_rdy_q || !run_q))
    else $error("enable ready high during pending disable");
  a_disable_at_cycle_end_ign: assert property ((s_cmd_wr and wdat[7] && !en_rdy_q && !disable_at_cycle_end_q)
    |=> !disable_at_cycle_end_q)
    else $error("disable strobe taken during enable sync");
endmodule : ctpwm_top

// ### test/ctpwm_switch_model.sv
`timescale 1ns/1ps
// power switch stage: counts how long each gate is driven on
module ctpwm_switch_model (
  input  wire logic            clock_in,
  input  wire logic            clear_in,
  input  wire logic [3:0]      gate_in,
  output logic      [3:0][7:0] on_time_out
);
  logic [3:0][7:0] on_q;
  logic [3:0][7:0] on_d;

  // conduction time grows while a gate is high, clear restarts it
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      on_d[i] = clear_in ? 8'h00 : on_q[i] + {7'h00, gate_in[i]};
    end
  end

  // state register
  always_ff @(posedge clock_in) begin
    on_q <= on_d;
  end

  assign on_time_out = on_q;
endmodule : ctpwm_switch_model

// ### test/control_timer_pwm_config_tb.sv
`timescale 1ns/1ps
`include "ctpwm_consts.svh"
// bus-level bench: register tasks, source ticks, switch conduction times
module control_timer_pwm_config_tb;
  import ctpwm_pkg::*;
  logic            clock_in    = 1'b0;
  logic            reset_in    = 1'b1;
  logic            osc_tick    = 1'b0;
  logic            ext_tick    = 1'b0;
  logic            psel        = 1'b0;
  logic            penable     = 1'b0;
  logic            pwrite      = 1'b0;
  logic [7:0]      paddr       = 8'h00;
  logic [31:0]     pwdata      = 32'h0;
  logic            sw_clear    = 1'b0;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  wire  [3:0]      gate;
  logic [3:0][7:0] on_time;
  logic [31:0]     rdat;
  logic            serr;
  logic [11:0]     c0;
  logic [11:0]     c1;
  logic [7:0]      lv;
  int              ea;
  int              eb;
  int              err_count   = 0;
  int              checks      = 0;
  int              cycle_count = 0;
  logic [5:0]      ri [4]      = '{`CTPWM_IDX_WAVE, `CTPWM_IDX_ROUTE, `CTPWM_IDX_OVR,
                                   `CTPWM_IDX_EVA};
  logic [7:0]      rm [4]      = '{8'h03, 8'hCB, 8'hFF, 8'hD5};
  logic [7:0]      cmpv [8]    = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h05, 8'h00, 8'h09, 8'h00};
  int              sh [3]      = '{0, 2, 5};

  ctpwm_top dut (
    .clock_in     (clock_in),
    .reset_in     (reset_in),
    .osc_tick_in  (osc_tick),
    .ext_tick_in  (ext_tick),
    .psel_in      (psel),
    .penable_in   (penable),
    .pwrite_in    (pwrite),
    .paddr_in     (paddr),
    .pwdata_in    (pwdata),
    .pstrb_in     (4'hF),
    .prdata_out   (prdata),
    .pready_out   (pready),
    .pslverr_out  (pslverr),
    .wave_a_out   (gate[0]),
    .wave_b_out   (gate[1]),
    .output_c_out (gate[2]),
    .output_d_out (gate[3])
  );

  ctpwm_switch_model switches (
    .clock_in    (clock_in),
    .clear_in    (sw_clear),
    .gate_in     (gate),
    .on_time_out (on_time)
  );

  // clock and hang guard
  always #10 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (err_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one bus transfer: setup, access held until pready
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clock_in);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clock_in);
    penable <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    rdat = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rd(input logic [5:0] idx);
    apb(1'b0, idx, 8'h00);
  endtask : rd

  task automatic st(input logic [1:0] e);
    rd(`CTPWM_IDX_STATUS);
    check("status", rdat, {30'h0, e});
  endtask : st

  task automatic wait_rdy(input logic [1:0] m);
    int n;
    n = 0;
    do begin
      rd(`CTPWM_IDX_STATUS);
      n++;
    end while ((rdat[1:0] & m) !== m && n < 40);
    check("ready bits", rdat[1:0] & m, m);
  endtask : wait_rdy

  // source ticks, one-cycle pulses two cycles apart
  task automatic tick(input int n, input logic ext);
    repeat (n) begin
      @(posedge clock_in);
      osc_tick <= ~ext;
      ext_tick <= ext;
      @(posedge clock_in);
      osc_tick <= 1'b0;
      ext_tick <= 1'b0;
    end
  endtask : tick

  task automatic cap(input logic [5:0] lo, output logic [11:0] c);
    rd(lo);
    c[7:0] = rdat[7:0];
    rd(lo + 6'h01);
    c[11:8] = rdat[3:0];
  endtask : cap

  task automatic measure(input int len);
    @(posedge clock_in);
    sw_clear <= 1'b1;
    @(posedge clock_in);
    sw_clear <= 1'b0;
    repeat (len) @(posedge clock_in);
    #1;
  endtask : measure

  // high time over two periods of state lengths 1, 2, 3, 4
  function automatic int exp_on(input int m, input logic o, input logic [3:0] v,
                                input logic b);
    int w[4] = '{2, 4, 6, 8};
    if (!o) return b ? 8 : 4;
    if (m == 0) return b ? v[3] * w[2] + v[2] * w[3] : v[1] * w[0] + v[0] * w[1];
    return v[0] * w[0] + v[1] * w[1] + v[2] * w[2] + v[3] * w[3];
  endfunction : exp_on

  // main sequence
  initial begin
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    st(2'b11);
    rd(`CTPWM_IDX_CLOCK);
    check("clock reset", rdat, 32'h0);
    rd(`CTPWM_IDX_CMD);
    check("strobes read", rdat, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rd(ri[i]);
      check("reset value", rdat, 32'h0);
      wr(ri[i], 8'hFF);
      rd(ri[i]);
      check("stored bits", rdat, {24'h0, rm[i]});
      wr(ri[i], 8'h00);
    end
    rd(6'h05);
    check("unmapped error", serr, 1'b1);
    check("unmapped data", rdat, 32'h0);
    // fifty copy and auto update with source ticks held back
    wr(`CTPWM_IDX_ROUTE, 8'h0A);
    wr(`CTPWM_IDX_CMP_FIRST + 6'h04, 8'h07);
    rd(`CTPWM_IDX_CMP_FIRST);
    check("fifty copy", rdat, 32'h07);
    wr(`CTPWM_IDX_CMP_FIRST + 6'h06, 8'hFF);
    wr(`CTPWM_IDX_CMP_FIRST + 6'h03, 8'h0F);
    st(2'b01);
    tick(2, 1'b0);
    st(2'b11);
    wr(`CTPWM_IDX_CMP_FIRST + 6'h07, 8'h0F);
    st(2'b01);
    tick(2, 1'b0);
    wr(`CTPWM_IDX_ROUTE, 8'h00);
    wr(`CTPWM_IDX_CMD, 8'h02);
    tick(2, 1'b0);
    st(2'b11);
    for (int d = 0; d < 4; d++) begin
      wr(`CTPWM_IDX_CLOCK, {5'h00, d[1:0], 1'b1});
      tick(1 << d, 1'b0);
      st(2'b10);
      tick(1 << d, 1'b0);
      st(2'b11);
      wr(`CTPWM_IDX_CLOCK, {5'h00, d[1:0], 1'b0});
      tick(2 << d, 1'b0);
    end
    wr(`CTPWM_IDX_CLOCK, 8'h00);
    tick(2, 1'b0);
    // counter advance between two captures per prescale
    for (int p = 0; p < 3; p++) begin
      wr(`CTPWM_IDX_CLOCK, {3'h0, p[1:0], 3'h1});
      tick(2, 1'b0);
      wr(`CTPWM_IDX_CMD, 8'h08);
      tick(2, 1'b0);
      cap(`CTPWM_IDX_CAPA_LO, c0);
      tick(62, 1'b0);
      wr(`CTPWM_IDX_CMD, 8'h10);
      tick(2, 1'b0);
      cap(`CTPWM_IDX_CAPB_LO, c1);
      check("capture gap", c1 - c0, 64 >> sh[p]);
      wr(`CTPWM_IDX_CLOCK, 8'h00);
      tick(2, 1'b0);
    end
    wr(`CTPWM_IDX_CLOCK, 8'h01);
    tick(22, 1'b0);
    wr(`CTPWM_IDX_CMD, 8'h04);
    wr(`CTPWM_IDX_CMD, 8'h10);
    tick(2, 1'b0);
    cap(`CTPWM_IDX_CAPB_LO, c0);
    check("dropped capture", c0, c1);
    wr(`CTPWM_IDX_CMD, 8'h08);
    tick(2, 1'b0);
    cap(`CTPWM_IDX_CAPA_LO, c0);
    check("restarted count", c0 <= 12'h003, 1'b1);
    wr(`CTPWM_IDX_CLOCK, 8'h00);
    tick(2, 1'b0);
    wr(`CTPWM_IDX_CLOCK, 8'h40);
    wr(`CTPWM_IDX_CMD, 8'h08);
    tick(4, 1'b0);
    st(2'b00);
    tick(2, 1'b1);
    st(2'b11);
    // system clock, period of ten counts
    wr(`CTPWM_IDX_CLOCK, 8'h60);
    for (int i = 0; i < 8; i++) wr(`CTPWM_IDX_CMP_FIRST + i[5:0], cmpv[i]);
    wr(`CTPWM_IDX_CMD, 8'h02);
    wait_rdy(2'b10);
    wr(`CTPWM_IDX_CLOCK, 8'h61);
    wait_rdy(2'b01);
    wr(`CTPWM_IDX_CLOCK, 8'h19);
    wait_rdy(2'b01);
    rd(`CTPWM_IDX_CLOCK);
    check("locked fields", rdat, 32'h61);
    for (int m = 0; m < 4; m++) begin
      for (int v = 0; v < 3; v++) begin
        lv = (v == 0) ? 8'h00 : ((v == 1) ? 8'h5A : 8'hC3);
        ea = exp_on(m, v != 0, lv[3:0], 1'b0);
        eb = exp_on(m, v != 0, lv[7:4], 1'b1);
        wr(`CTPWM_IDX_WAVE, {6'h00, m[1:0]});
        wr(`CTPWM_IDX_OVR, lv);
        wr(`CTPWM_IDX_ROUTE, {m[1], m[0], 5'h00, v != 0});
        measure(20);
        check("wave a time", on_time[0], ea);
        check("wave b time", on_time[1], eb);
        check("output c time", on_time[2], m[0] ? eb : ea);
        check("output d time", on_time[3], m[1] ? eb : ea);
      end
    end
    // new clear point loaded at a cycle end
    wr(`CTPWM_IDX_ROUTE, 8'h02);
    wr(`CTPWM_IDX_CMP_FIRST + 6'h06, 8'h0B);
    wr(`CTPWM_IDX_CMP_FIRST + 6'h07, 8'h00);
    wait_rdy(2'b10);
    repeat (12) @(posedge clock_in);
    measure(24);
    check("auto update", on_time[1], 32'd12);
    wr(`CTPWM_IDX_ROUTE, 8'h00);
    wr(`CTPWM_IDX_CMP_FIRST + 6'h06, 8'h09);
    wr(`CTPWM_IDX_CMD, 8'h01);
    wait_rdy(2'b10);
    repeat (12) @(posedge clock_in);
    measure(20);
    check("end sync", on_time[1], 32'd8);
    wr(`CTPWM_IDX_CMD, 8'h80);
    wait_rdy(2'b01);
    measure(20);
    check("stopped", on_time[0] == 8'd0 || on_time[0] == 8'd20, 1'b1);
    wr(`CTPWM_IDX_CLOCK, 8'h21);
    tick(4, 1'b0);
    tick(4, 1'b1);
    st(2'b10);
    @(posedge clock_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    st(2'b11);
    rd(`CTPWM_IDX_CLOCK);
    check("clock after reset", rdat, 32'h0);
    print_verdict();
  end
endmodule : control_timer_pwm_config_tb
